// *** rtl/ldm_link_if.sv ***
// carrier between the serial-clock receiver and the mode controller
interface ldm_link_if;
	logic [15:0] word;   // last sixteen bits shifted in
	logic [7:0]  edges;  // running count of rising serial clock edges while selected
	logic        rst_b;  // receiver clear, low active
	modport rx   (output word, edges, input rst_b);
	modport core (input word, edges, output rst_b);
endinterface : ldm_link_if

// *** rtl/ldm_link_rx.sv ***
// serial receiver running on the link clock
module ldm_link_rx
	import ldm_pkg::*;
(
	// link pins
	input  wire logic spi_sck_i,
	input  wire logic spi_ssn_b_i,
	input  wire logic spi_mosi_i,
	// toward the controller
	ldm_link_if.rx    link
);
	logic [FR_BITS-1:0] shift;
	logic [EDGE_W-1:0]  edges;
	logic [FR_BITS-1:0] next_shift;
	logic [EDGE_W-1:0]  next_edges;

	// shift msb first while selected; edges keep counting across frames
	always_comb begin
		next_shift = shift;
		next_edges = edges;
		if (!spi_ssn_b_i) begin
			next_shift = {shift[FR_BITS-2:0], spi_mosi_i};
			next_edges = edges + 8'h01;
		end
	end

	// link clock may stop, so the clear is taken without it
	always_ff @(posedge spi_sck_i or negedge link.rst_b) begin
		if (!link.rst_b) begin
			shift <= '0;
			edges <= '0;
		end else begin
			shift <= next_shift;
			edges <= next_edges;
		end
	end

	assign link.word  = shift;
	assign link.edges = edges;
endmodule : ldm_link_rx

// *** rtl/ldm_mode_ctrl.sv ***
// operating-mode controller of the dual channel led buck driver
module ldm_mode_ctrl
	import ldm_pkg::*;
#(
	parameter int unsigned FAULT_CYC = FAULT_CYC_DEF
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_b_i,
	// supply monitors
	input  wire logic             analog_supply_uv_i,
	input  wire logic             digital_supply_uv_i,
	// serial link
	input  wire logic             spi_sck_i,
	input  wire logic             spi_ssn_b_i,
	input  wire logic             spi_mosi_i,
	// comparators and pins
	input  wire logic [1:0]       neg_current_sense_low_i,
	input  wire logic [1:0]       bootstrap_low_i,
	input  wire logic [1:0]       dimming_input_i,
	// same-clock sources
	input  wire logic [9:0]       limp_ref_adc_i,
	input  wire logic             limp_ref_adc_valid_i,
	input  wire logic [1:0]       latched_fault_i,
	input  wire logic [1:0]       restart_fault_i,
	input  wire logic [4:0]       watchdog_tap_i,
	// mode and channel control
	output ldm_mode_e             mode_o,
	output logic [1:0]            channel_enable_bit_o,
	output logic [1:0]            channel_drive_o,
	output logic [1:0]            comp_discharge_o,
	output logic [1:0]            bootstrap_protect_o,
	output logic                  osc_enable_o,
	output logic                  fixed_freq_o,
	output logic                  default_fault_timer_o,
	output logic                  ref_from_pin_o,
	output logic [1:0][9:0]       current_ref_o,
	// status
	output logic [1:0]            output_short_flag_o,
	output logic [1:0]            bootstrap_uv_flag_o,
	output logic [1:0]            watchdog_timeout_bits_o,
	output logic                  power_cycled_flag_o,
	output logic [9:0]            limp_ref_raw_o,
	output logic [9:0]            filtered_ref_regs_o
);
	ldm_link_if link ();

	ldm_link_rx u_rx (
		.spi_sck_i   (spi_sck_i),
		.spi_ssn_b_i (spi_ssn_b_i),
		.spi_mosi_i  (spi_mosi_i),
		.link        (link.rx)
	);

	// address and direction match on a received frame
	function automatic logic hit(input logic [15:0] w, input logic [5:0] a, input logic wr);
		return (w[FR_CMD] == wr) && (w[FR_ADDR_MSB:FR_ADDR_LSB] == a);
	endfunction : hit

	// pin synchronisers, two flops each, three on the select
	logic [1:0]  uv_q1, uv_q2, csn_q1, csn_q2, bst_q1, bst_q2, dim_q1, dim_q2;
	logic        ssn_q1, ssn_q2, ssn_q3, link_rst_b;
	logic        hold;
	always_ff @(posedge core_clk_i) begin
		uv_q1  <= {analog_supply_uv_i, digital_supply_uv_i};
		uv_q2  <= uv_q1;
		csn_q1 <= neg_current_sense_low_i;
		csn_q2 <= csn_q1;
		bst_q1 <= bootstrap_low_i;
		bst_q2 <= bst_q1;
		dim_q1 <= dimming_input_i;
		dim_q2 <= dim_q1;
		ssn_q1 <= spi_ssn_b_i;
		ssn_q2 <= ssn_q1;
		ssn_q3 <= ssn_q2;
		link_rst_b <= !hold;
	end
	assign hold       = !rst_b_i || (uv_q2 != 2'h0);
	assign link.rst_b = link_rst_b;

	// frame capture: the edge count is quiet around select edges
	logic [EDGE_W-1:0] start_edges, next_start, span;
	logic [15:0]       w;
	logic              ssn_rise, fr_ok;
	always_comb begin
		ssn_rise   = ssn_q2 && !ssn_q3;
		w          = link.word;
		span       = link.edges - start_edges;
		next_start = (!ssn_q2 && ssn_q3) ? link.edges : start_edges;
		fr_ok = ssn_rise && (span[3:0] == FR_MOD_ZERO) && (span != '0)
			&& (w[FR_PAR] == ~^{w[FR_CMD:FR_ADDR_LSB], w[7:0]})
			&& (w[FR_CMD] || (w[7:0] == 8'h00));
	end
	always_ff @(posedge core_clk_i) begin
		start_edges <= hold ? '0 : next_start;
	end

	// decoded accesses, only error-free frames count
	logic wr_sys, wr_sleep, wr_reset, rd_st1, rd_st2, rd_st3;
	logic sleep_enter, wake, to_load_code, to_detect_code, sw_default;
	always_comb begin
		wr_sys   = fr_ok && hit(w, ADDR_SYSTEM_CONFIG_ONE, 1'b1);
		wr_sleep = fr_ok && hit(w, ADDR_SLEEP, 1'b1);
		wr_reset = fr_ok && hit(w, ADDR_RESET, 1'b1);
		rd_st1   = fr_ok && hit(w, ADDR_FIRST_STATUS_REG, 1'b0);
		rd_st2   = fr_ok && hit(w, ADDR_SECOND_STATUS_REG, 1'b0);
		rd_st3   = fr_ok && hit(w, ADDR_THIRD_STATUS_REG, 1'b0);
		sleep_enter    = wr_sleep && (w[1:0] == SLEEP_ENTER);
		wake           = wr_sleep && (w[1:0] == SLEEP_WAKE);
		to_load_code   = wr_reset && (w[7:0] == RST_TO_LOAD);
		to_detect_code = wr_reset && (w[7:0] == RST_TO_DETECT)
			&& (watchdog_timeout_bits_o == 2'h0);
		sw_default = (mode_o == MODE_STANDALONE) && (to_load_code || to_detect_code);
	end

	// communication watchdog and consecutive timeout count
	logic [WDT_W-1:0] wd_cnt, next_wd_cnt;
	logic [1:0]       consec, next_consec, next_wdto;
	logic             wd_run, wd_to, wdt_en;
	always_comb begin
		// standalone, sleep and limp-home leave the watchdog stopped
		wd_run = (mode_o == MODE_DETECT)
			|| (wdt_en && (mode_o == MODE_LOAD || mode_o == MODE_RUN));
		wd_to       = wd_run && wd_cnt[watchdog_tap_i];
		next_wd_cnt = (!wd_run || fr_ok || wd_to) ? '0 : wd_cnt + 25'h1;
		next_consec = consec;
		if (fr_ok || sw_default) begin
			next_consec = 2'h0;
		end else if (wd_to && consec != WDT_LIMP_CNT) begin
			next_consec = consec + 2'h1;
		end
		// a timeout landing on the clearing read still counts
		next_wdto = watchdog_timeout_bits_o;
		if (wd_to) begin
			next_wdto = rd_st3 ? 2'h1 : (next_wdto == 2'h3 ? 2'h3 : next_wdto + 2'h1);
		end else if (rd_st3 || sw_default) begin
			next_wdto = 2'h0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (hold) begin
			wd_cnt <= '0;
			consec <= '0;
			watchdog_timeout_bits_o <= '0;
		end else begin
			wd_cnt <= sw_default ? '0 : next_wd_cnt;
			consec <= next_consec;
			watchdog_timeout_bits_o <= next_wdto;
		end
	end

	// configuration bits written over the link
	logic       limp_sel, ext_sel, next_limp_sel, next_ext_sel, next_wdt_en;
	logic [1:0] next_ch_en;
	logic [7:0] limp_cur [2];
	logic [7:0] next_limp_cur [2];
	logic       cfg_open;
	ldm_mode_e  next_mode;
	always_comb begin
		// sleep and standalone take no configuration writes; sleep still hears its own register, standalone the reset codes
		cfg_open      = (mode_o != MODE_SLEEP) && (mode_o != MODE_STANDALONE);
		next_ch_en    = channel_enable_bit_o;
		next_limp_sel = limp_sel;
		next_wdt_en   = wdt_en;
		next_ext_sel  = ext_sel;
		next_limp_cur = limp_cur;
		if (wr_sys && cfg_open) begin
			next_ch_en  = w[1:0];
			next_wdt_en = w[SYS_WDT_BIT];
			// limp bit stays set until the timeout bits were read away
			if (mode_o != MODE_LIMP || watchdog_timeout_bits_o == 2'h0) begin
				next_limp_sel = w[SYS_LIMP_BIT];
			end
		end
		if (fr_ok && cfg_open && hit(w, ADDR_LIMP_CUR0, 1'b1)) next_limp_cur[0] = w[7:0];
		if (fr_ok && cfg_open && hit(w, ADDR_LIMP_CUR1, 1'b1)) next_limp_cur[1] = w[7:0];
		if (fr_ok && cfg_open && hit(w, ADDR_LIMP_CFG1, 1'b1)) next_ext_sel = w[LIMP_EXT_BIT];
		if (mode_o == MODE_RUN) begin
			next_ch_en = next_ch_en & ~latched_fault_i;
		end
		if (next_mode == MODE_SLEEP) begin
			next_ch_en = 2'h0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (hold || sw_default) begin
			channel_enable_bit_o <= CH_EN_RST;
			limp_sel <= 1'b0;
			wdt_en   <= WDT_EN_RST;
			ext_sel  <= 1'b0;
			limp_cur <= '{8'h00, 8'h00};
		end else begin
			channel_enable_bit_o <= next_ch_en;
			limp_sel <= next_limp_sel;
			wdt_en   <= next_wdt_en;
			ext_sel  <= next_ext_sel;
			limp_cur <= next_limp_cur;
		end
	end

	// operating mode state machine
	logic limp_enter;
	always_comb begin
		limp_enter = limp_sel || (wdt_en && consec == WDT_LIMP_CNT);
		next_mode  = mode_o;
		case (mode_o)
			MODE_POR: next_mode = MODE_DETECT;
			MODE_DETECT: begin
				if (fr_ok) next_mode = MODE_LOAD;
				else if (wd_to) next_mode = MODE_STANDALONE;
			end
			MODE_STANDALONE: begin
				if (to_load_code) next_mode = MODE_LOAD;
				else if (to_detect_code) next_mode = MODE_DETECT;
			end
			MODE_LOAD: begin
				if (limp_enter) next_mode = MODE_LIMP;
				else if (sleep_enter) next_mode = MODE_SLEEP;
				else if (!power_cycled_flag_o && channel_enable_bit_o != 2'h0) begin
					next_mode = MODE_RUN;
				end
			end
			MODE_RUN: begin
				if (latched_fault_i != 2'h0) next_mode = MODE_LOAD;
				else if (limp_enter) next_mode = MODE_LIMP;
				else if (sleep_enter) next_mode = MODE_SLEEP;
				else if (channel_enable_bit_o == 2'h0) next_mode = MODE_LOAD;
			end
			MODE_SLEEP: if (wake) next_mode = MODE_LOAD;
			MODE_LIMP: begin
				if (wr_sys && !w[SYS_LIMP_BIT] && watchdog_timeout_bits_o == 2'h0) begin
					next_mode = MODE_LOAD;
				end
			end
			default: next_mode = MODE_POR;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		mode_o <= hold ? MODE_POR : next_mode;
	end

	// sticky status flags, set wins over the clearing read
	logic [1:0] next_short, next_bstuv;
	logic       next_pc;
	always_comb begin
		next_short = 2'h0;
		next_bstuv = 2'h0;
		next_short = csn_q2 | (output_short_flag_o & {2{!rd_st1}});
		next_bstuv = bst_q2 | (bootstrap_uv_flag_o & {2{!rd_st2}});
		next_pc    = (power_cycled_flag_o && !rd_st3) || sw_default;
	end
	always_ff @(posedge core_clk_i) begin
		if (hold) begin
			output_short_flag_o <= '0;
			bootstrap_uv_flag_o <= '0;
			bootstrap_protect_o <= '0;
			power_cycled_flag_o <= PC_RST;
		end else begin
			output_short_flag_o <= next_short;
			bootstrap_uv_flag_o <= next_bstuv;
			bootstrap_protect_o <= bst_q2;
			power_cycled_flag_o <= next_pc;
		end
	end

	// reference pin: raw value, low-pass filter and hysteresis
	logic [9:0]        next_raw, next_filt;
	logic signed [10:0] diff, step;
	logic              ref_ok, next_ref_ok;
	always_comb begin
		diff      = $signed({1'b0, limp_ref_adc_i}) - $signed({1'b0, filtered_ref_regs_o});
		step      = diff >>> FILT_SHIFT;
		next_raw  = limp_ref_raw_o;
		next_filt = filtered_ref_regs_o;
		if (limp_ref_adc_valid_i) begin
			next_raw  = limp_ref_adc_i;
			next_filt = 10'($signed({1'b0, filtered_ref_regs_o}) + step);
		end
		// the gap between the thresholds rejects flicker from pin noise
		next_ref_ok = ref_ok;
		if (filtered_ref_regs_o < REF_LOW_CODE) next_ref_ok = 1'b0;
		else if (filtered_ref_regs_o > REF_HIGH_CODE) next_ref_ok = 1'b1;
	end
	always_ff @(posedge core_clk_i) begin
		if (hold) begin
			limp_ref_raw_o      <= '0;
			filtered_ref_regs_o <= '0;
			ref_ok              <= 1'b0;
		end else begin
			limp_ref_raw_o      <= next_raw;
			filtered_ref_regs_o <= next_filt;
			ref_ok              <= next_ref_ok;
		end
	end

	// per-channel restart timer for faults that recover on their own
	logic [1:0] waiting;
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_restart
			logic [FT_W-1:0] ft_cnt, next_ft;
			logic            trig;
			always_comb begin
				// standalone turns latched faults into auto-restart ones
				trig    = restart_fault_i[c]
					|| (mode_o == MODE_STANDALONE && latched_fault_i[c]);
				next_ft = ft_cnt;
				if (trig) next_ft = FT_W'(FAULT_CYC - 1);
				else if (ft_cnt != '0) next_ft = ft_cnt - 18'h1;
			end
			always_ff @(posedge core_clk_i) begin
				ft_cnt <= hold ? '0 : next_ft;
			end
			assign waiting[c] = (ft_cnt != '0);
		end
	endgenerate

	// channel drive and mode-dependent outputs, short flags never gate them
	logic [1:0]      next_drive, next_dis;
	logic [1:0][9:0] next_ref;
	always_comb begin
		next_drive = 2'h0;
		next_dis   = 2'h0;
		next_ref   = '0;
		case (mode_o)
			MODE_RUN: begin
				next_drive = channel_enable_bit_o & ~latched_fault_i & ~waiting
					& {2{!limp_sel}};
				next_dis   = latched_fault_i;
			end
			MODE_STANDALONE: begin
				next_drive = dim_q2 & ~waiting & {2{ref_ok}};
				next_ref   = {filtered_ref_regs_o, filtered_ref_regs_o};
			end
			MODE_LIMP: begin
				next_drive = ~waiting & {2{!ext_sel || ref_ok}};
				next_ref   = ext_sel ? {filtered_ref_regs_o, filtered_ref_regs_o}
					: {limp_cur[1], 2'h0, limp_cur[0], 2'h0};
			end
			default: next_drive = 2'h0;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (hold) begin
			channel_drive_o       <= '0;
			comp_discharge_o      <= '0;
			current_ref_o         <= '0;
			osc_enable_o          <= 1'b0;
			fixed_freq_o          <= 1'b0;
			default_fault_timer_o <= 1'b0;
			ref_from_pin_o        <= 1'b0;
		end else begin
			channel_drive_o       <= next_drive;
			comp_discharge_o      <= next_dis;
			current_ref_o         <= next_ref;
			osc_enable_o          <= (mode_o != MODE_SLEEP);
			fixed_freq_o          <= (mode_o == MODE_STANDALONE);
			default_fault_timer_o <= (mode_o == MODE_STANDALONE);
			ref_from_pin_o        <= (mode_o == MODE_STANDALONE) || (mode_o == MODE_LIMP && ext_sel);
		end
	end

	// checks on the controller
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_third_timeout;
		wd_to && !fr_ok && consec == 2'h2 && wdt_en && mode_o == MODE_LOAD;
	endsequence

	a_short_sets: assert property (!hold && csn_q2[0] |=> output_short_flag_o[0])
		else $error("short flag not set");
	a_bst_flag: assert property (!hold && bst_q2[1]
		|=> bootstrap_uv_flag_o[1] && bootstrap_protect_o[1])
		else $error("bootstrap flag not set");
	a_uv_hold: assert property (uv_q2 != 2'h0 |=> mode_o == MODE_POR && channel_drive_o == 2'h0)
		else $error("undervoltage did not hold reset");
	a_detect_to: assert property (mode_o == MODE_DETECT && wd_to && !fr_ok
		|=> mode_o == MODE_STANDALONE)
		else $error("watchdog timeout missed standalone");
	a_detect_load: assert property (mode_o == MODE_DETECT && fr_ok |=> mode_o == MODE_LOAD && wd_cnt == '0)
		else $error("valid frame missed load");
	a_pc_blocks: assert property (mode_o == MODE_LOAD && power_cycled_flag_o |=> mode_o != MODE_RUN)
		else $error("left load with power-cycled flag");
	a_run_limp_off: assert property (mode_o == MODE_RUN && limp_sel |=> channel_drive_o == 2'h0)
		else $error("switching with limp bit set");
	a_latch_back: assert property (mode_o == MODE_RUN && latched_fault_i != 2'h0
		|=> mode_o == MODE_LOAD && comp_discharge_o != 2'h0)
		else $error("latched fault not handled");
	a_limp_three: assert property (s_third_timeout |-> ##2 mode_o == MODE_LIMP)
		else $error("third timeout missed limp-home");
	a_sleep_quiet: assert property (mode_o == MODE_SLEEP [*2] |-> !osc_enable_o && channel_drive_o == 2'h0)
		else $error("sleep left oscillator or channel on");
	a_ref_hyst: assert property (!ref_ok && filtered_ref_regs_o <= REF_HIGH_CODE |=> !ref_ok)
		else $error("reference re-enabled inside hysteresis");
endmodule : ldm_mode_ctrl

// *** rtl/ldm_pkg.sv ***
// shared constants, codes and the mode type of the led driver mode controller
package ldm_pkg;
	// core clock and restart timing
	localparam int unsigned CLK_MHZ       = 50;
	localparam int unsigned FAULT_TIME_US = 3600;  // 3.6 ms restart wait
	localparam int unsigned FAULT_CYC_DEF = FAULT_TIME_US * CLK_MHZ;
	localparam int unsigned FT_W          = 18;
	// communication watchdog
	localparam int unsigned WDT_W         = 25;
	localparam logic [1:0]  WDT_LIMP_CNT  = 2'h3;  // consecutive timeouts into limp-home
	// serial frame layout: cmd, six address bits, parity, eight data bits
	localparam int unsigned FR_BITS       = 16;
	localparam int unsigned FR_CMD        = 15;
	localparam int unsigned FR_ADDR_MSB   = 14;
	localparam int unsigned FR_ADDR_LSB   = 9;
	localparam int unsigned FR_PAR        = 8;
	localparam int unsigned EDGE_W        = 8;
	localparam logic [3:0]  FR_MOD_ZERO   = 4'h0;
	// register offsets
	localparam logic [5:0]  ADDR_SYSTEM_CONFIG_ONE  = 6'h01;
	localparam logic [5:0]  ADDR_FIRST_STATUS_REG  = 6'h02;
	localparam logic [5:0]  ADDR_SECOND_STATUS_REG  = 6'h03;
	localparam logic [5:0]  ADDR_THIRD_STATUS_REG  = 6'h04;
	localparam logic [5:0]  ADDR_SLEEP    = 6'h05;
	localparam logic [5:0]  ADDR_RESET    = 6'h06;
	localparam logic [5:0]  ADDR_LIMP_CUR0 = 6'h1e;
	localparam logic [5:0]  ADDR_LIMP_CUR1 = 6'h1f;
	localparam logic [5:0]  ADDR_LIMP_CFG1 = 6'h20;
	// command codes
	localparam logic [7:0]  RST_TO_LOAD   = 8'hc3;
	localparam logic [7:0]  RST_TO_DETECT = 8'hd4;
	localparam logic [1:0]  SLEEP_ENTER   = 2'h1;
	localparam logic [1:0]  SLEEP_WAKE    = 2'h0;
	// field positions
	localparam int unsigned SYS_LIMP_BIT  = 2;
	localparam int unsigned SYS_WDT_BIT   = 3;
	localparam int unsigned LIMP_EXT_BIT  = 0;
	// reference pin conversion and hysteresis
	localparam int unsigned ADC_FS_MV     = 2500;
	localparam int unsigned ADC_CODES     = 1024;
	localparam int unsigned REF_LOW_MV    = 148;
	localparam int unsigned REF_HIGH_MV   = 200;
	localparam logic [9:0]  REF_LOW_CODE  = 10'(REF_LOW_MV * ADC_CODES / ADC_FS_MV);
	localparam logic [9:0]  REF_HIGH_CODE = 10'(REF_HIGH_MV * ADC_CODES / ADC_FS_MV);
	localparam int unsigned FILT_SHIFT    = 3;
	// reset values
	localparam logic [1:0]  CH_EN_RST     = 2'h0;
	localparam logic        WDT_EN_RST    = 1'b1;
	localparam logic        PC_RST        = 1'b1;
	// operating modes
	typedef enum logic [2:0] {
		MODE_POR, MODE_DETECT, MODE_STANDALONE, MODE_LOAD, MODE_RUN, MODE_SLEEP, MODE_LIMP
	} ldm_mode_e;
endpackage : ldm_pkg

// *** tb/dual_led_driver_mode_fsm_bench.sv ***
// self-checking bench of the led driver mode controller
module dual_led_driver_mode_fsm_bench import ldm_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_b, uv, auv, adc_v;
	logic sck, ssn_b, mosi;
	logic [1:0] sense, bst, dim, lf, en, drv, sflag, bflag, bprot, wdto, cdis;
	logic [9:0] adc, raw, filt;
	logic [1:0][9:0] cref;
	logic [7:0] lc;
	logic [4:0] tap;
	logic osc, ffreq, dft, pin, pc;
	ldm_mode_e mode;
	int error_cnt, cmp_count, cyc_cnt, seed;
	ldm_spi_master m (.spi_sck_o(sck), .spi_ssn_b_o(ssn_b), .spi_mosi_o(mosi));
	ldm_mode_ctrl #(.FAULT_CYC(20)) DUT (.core_clk_i(clk), .rst_b_i(rst_b),
		.analog_supply_uv_i(auv), .digital_supply_uv_i(uv), .spi_sck_i(sck),
		.spi_ssn_b_i(ssn_b), .spi_mosi_i(mosi), .neg_current_sense_low_i(sense),
		.bootstrap_low_i(bst), .dimming_input_i(dim), .limp_ref_adc_i(adc),
		.limp_ref_adc_valid_i(adc_v), .latched_fault_i(lf), .restart_fault_i(2'h0),
		.watchdog_tap_i(tap), .mode_o(mode), .channel_enable_bit_o(en),
		.channel_drive_o(drv), .comp_discharge_o(cdis), .bootstrap_protect_o(bprot),
		.osc_enable_o(osc), .fixed_freq_o(ffreq), .default_fault_timer_o(dft),
		.ref_from_pin_o(pin), .current_ref_o(cref), .output_short_flag_o(sflag),
		.bootstrap_uv_flag_o(bflag), .watchdog_timeout_bits_o(wdto),
		.power_cycled_flag_o(pc), .limp_ref_raw_o(raw), .filtered_ref_regs_o(filt));
	// 50 MHz core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	// hang guard, far above the whole sequence
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// bounded wait for a mode, then compare
	task automatic wait_mode(input ldm_mode_e e, input int lim);
		for (int k = 0; k < lim && mode !== e; k++) cyc(1);
		chk("mode", 10'(mode), 10'(e));
	endtask : wait_mode
	// frame with odd parity over command, address and data
	task automatic xfer(input logic c, input logic [5:0] a, input logic [7:0] d);
		m.send({c, a, ~^{c, a, d}, d});
		cyc(6); // decode plus mode and drive update
	endtask : xfer
	// forty back-to-back samples, valid held high rather than re-pulsed
	task automatic feed(input logic [9:0] v);
		adc = v;
		adc_v = 1'b1;
		cyc(40);
		adc_v = 1'b0;
		cyc(4);
	endtask : feed
	// main sequence
	initial begin
		seed = 94116;
		{rst_b, uv, auv, adc_v, sense, bst, dim, lf, adc} = '0;
		tap = 5'h04;
		cyc(10);
		chk("mode", 10'(mode), 10'(MODE_POR));
		chk("pc", 10'(pc), 10'h1);
		rst_b = 1'b1;
		cyc(12);
		chk("mode", 10'(mode), 10'(MODE_DETECT));
		wait_mode(MODE_STANDALONE, 12);
		cyc(1); // mode-dependent outputs trail the mode by one edge
		chk("std", 10'({ffreq, dft, pin}), 10'h7);
		chk("wdto", 10'(wdto), 10'h1);
		dim = 2'($random(seed)) | 2'h1;
		feed(10'h3ff);
		chk("raw", raw, 10'h3ff);
		chk("filt", 10'(filt > REF_HIGH_CODE), 10'h1);
		chk("drive", 10'(drv), 10'(dim));
		feed(10'h000);
		chk("filt", 10'(filt < REF_LOW_CODE), 10'h1);
		chk("drive", 10'(drv), 10'h0);
		$display("standalone test done");
		tap = 5'h14;
		xfer(1'b1, ADDR_RESET, RST_TO_LOAD);
		wait_mode(MODE_LOAD, 4);
		chk("pc", 10'(pc), 10'h1);
		xfer(1'b0, ADDR_THIRD_STATUS_REG, 8'h00);
		chk("pc", 10'(pc), 10'h0);
		sense = 2'($random(seed)) | 2'h1;
		bst = 2'($random(seed)) | 2'h2;
		cyc(5);
		chk("short", 10'(sflag), 10'(sense));
		chk("bst", 10'(bflag), 10'(bst));
		chk("bprot", 10'(bprot), 10'(bst));
		xfer(1'b1, ADDR_SYSTEM_CONFIG_ONE, 8'h09);
		wait_mode(MODE_RUN, 4);
		chk("drive", 10'(drv[0]), 10'h1);
		lf = 2'h1;
		wait_mode(MODE_LOAD, 6);
		chk("dis", 10'(cdis), 10'h1);
		chk("en", 10'(en), 10'h0);
		lf = 2'h0;
		$display("load run test done");
		xfer(1'b1, ADDR_SLEEP, 8'h01);
		wait_mode(MODE_SLEEP, 4);
		chk("osc", 10'(osc), 10'h0);
		xfer(1'b1, ADDR_SLEEP, 8'h00);
		wait_mode(MODE_LOAD, 4);
		// limp current programmed while still in load
		lc = 8'($random(seed));
		xfer(1'b1, ADDR_LIMP_CUR0, lc);
		tap = 5'h04;
		wait_mode(MODE_LIMP, 120);
		cyc(1);
		chk("cref", cref[0], {lc, 2'h0});
		chk("drive", 10'(drv), 10'h3);
		tap = 5'h14;
		// timeout bits still set, so the exit write is ignored
		xfer(1'b1, ADDR_SYSTEM_CONFIG_ONE, 8'h08);
		chk("mode", 10'(mode), 10'(MODE_LIMP));
		xfer(1'b0, ADDR_THIRD_STATUS_REG, 8'h00);
		xfer(1'b1, ADDR_SYSTEM_CONFIG_ONE, 8'h08);
		wait_mode(MODE_LOAD, 4);
		xfer(1'b1, ADDR_SYSTEM_CONFIG_ONE, 8'h0c);
		chk("mode", 10'(mode), 10'(MODE_LIMP));
		xfer(1'b1, ADDR_SYSTEM_CONFIG_ONE, 8'h08);
		wait_mode(MODE_LOAD, 4);
		// each supply monitor alone holds the block in reset
		{auv, uv} = 2'h2;
		wait_mode(MODE_POR, 5);
		chk("pc", 10'(pc), 10'h1);
		{auv, uv} = 2'h1;
		cyc(3);
		chk("mode", 10'(mode), 10'(MODE_POR));
		tap = 5'h04;
		{auv, uv} = 2'h0;
		wait_mode(MODE_DETECT, 5);
		wait_mode(MODE_STANDALONE, 24);
		// back to detect needs the timeout bits read away first
		xfer(1'b1, ADDR_RESET, RST_TO_DETECT);
		chk("mode", 10'(mode), 10'(MODE_STANDALONE));
		xfer(1'b0, ADDR_THIRD_STATUS_REG, 8'h00);
		xfer(1'b1, ADDR_RESET, RST_TO_DETECT);
		wait_mode(MODE_DETECT, 4);
		$display("sleep limp supply test done");
		summarize();
	end
endmodule : dual_led_driver_mode_fsm_bench

// *** tb/ldm_spi_master.sv ***
// serial bus master model standing in for the microcontroller
module ldm_spi_master (
	// link pins
	output logic spi_sck_o,
	output logic spi_ssn_b_o,
	output logic spi_mosi_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: clock stands still between frames, select high
	initial begin
		spi_sck_o = 1'b0;
		spi_ssn_b_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// whole 16-bit frame, msb first, 15 ns link clock, quiet gaps at both ends
	task automatic send(input logic [15:0] w);
		spi_ssn_b_o = 1'b0;
		#70;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi_o = w[i];
			#7.5 spi_sck_o = 1'b1;
			#7.5 spi_sck_o = 1'b0;
		end
		#70;
		spi_ssn_b_o = 1'b1;
		spi_mosi_o = ~w[0]; // released line must not look held
		#100; // select stays high for five core cycles
	endtask : send
endmodule : ldm_spi_master
